// ==== logic/edm_pkg.sv ====
package edm_pkg;

	// Register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_STATUS  = 8'h04;
	localparam logic [7:0] OFS_TX_POLL = 8'h08;
	localparam logic [7:0] OFS_RX_POLL = 8'h0c;
	localparam logic [7:0] OFS_RX_BASE = 8'h10;
	localparam logic [7:0] OFS_TX_BASE = 8'h14;
	localparam logic [7:0] OFS_TX_CUR  = 8'h18;
	localparam logic [7:0] OFS_RX_CUR  = 8'h1c;

	// dma_control_reg bits
	localparam int CTRL_RX_START = 1;
	localparam int CTRL_TX_START = 13;

	// Descriptor fields
	localparam int DESC_OWN   = 31;
	localparam int TX_W1_LS   = 30;
	localparam int TX_W1_FS   = 29;
	localparam int TX_W0_IOC  = 30;
	localparam int TX_W0_ERR  = 15;
	localparam int RX_W0_FS   = 9;
	localparam int RX_W0_LS   = 8;
	localparam int RX_LEN_LSB = 16;
	localparam int SIZE_W     = 11;
	localparam int WCNT_W     = 10;
	localparam int LEN_W      = 14;
	localparam logic [1:0]  DESC_LAST_IDX = 2'h3;
	localparam logic [31:0] WORD_BYTES    = 32'h4;
	localparam logic [11:0] BYTE_ROUND    = 12'h3;
	localparam int WORD_SHIFT = 2;

	// dma_status_reg sticky flag positions, flag count and state field offsets
	localparam int ST_TI   = 0;
	localparam int ST_TU   = 2;
	localparam int ST_RI   = 6;
	localparam int ST_RU   = 7;
	localparam int ST_RPS  = 8;
	localparam int ST_AIS  = 15;
	localparam int ST_NIS  = 16;
	localparam int NFLAG   = 17;
	localparam int ST_RS_LSB = 17;
	localparam int ST_TS_LSB = 20;

	// Process state codes
	localparam logic [2:0] PS_STOP = 3'h0;
	localparam logic [2:0] PS_RUN  = 3'h3;
	localparam logic [2:0] PS_SUSP = 3'h4;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [31:0] addr;
		logic [31:0] wdata;
	} edm_mreq_t;

	typedef struct packed {
		logic        ack;
		logic        err;
		logic [31:0] rdata;
	} edm_mrsp_t;

	typedef enum logic [5:0] {
		TX_STOP  = 6'b000001,
		TX_FETCH = 6'b000010,
		TX_CHECK = 6'b000100,
		TX_DATA  = 6'b001000,
		TX_CLOSE = 6'b010000,
		TX_SUSP  = 6'b100000
	} edm_tx_state_t;

	typedef enum logic [7:0] {
		RX_STOP  = 8'b00000001,
		RX_FETCH = 8'b00000010,
		RX_CHECK = 8'b00000100,
		RX_WAIT  = 8'b00001000,
		RX_DATA  = 8'b00010000,
		RX_CLOSE = 8'b00100000,
		RX_SUSP  = 8'b01000000,
		RX_DROP  = 8'b10000000
	} edm_rx_state_t;

endpackage : edm_pkg

// ==== logic/edm_flags.sv ====
`timescale 1ns/100ps
`default_nettype none
module edm_flags
	import edm_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [NFLAG-1:0] set_i,
	input  wire logic [NFLAG-1:0] clr_i,
	output logic      [NFLAG-1:0] flag_o
);

	typedef struct packed {
		logic [NFLAG-1:0] flag;
	} edm_flags_st_t;

	edm_flags_st_t st;
	edm_flags_st_t next_st;

	// Sticky bits; a set in the clearing cycle wins so no event is lost
	for (genvar i = 0; i < NFLAG; i++)
	begin : g_flag
		always_comb
		begin
			next_st.flag[i] = set_i[i] | (st.flag[i] & ~clr_i[i]);
		end
	end

	// State register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			st <= '0;
		else
			st <= next_st;
	end

	assign flag_o = st.flag;

endmodule : edm_flags
`default_nettype wire

// ==== logic/edm_mem_arb.sv ====
`timescale 1ns/100ps
`default_nettype none
module edm_mem_arb
	import edm_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire edm_mreq_t   tx_req_i,
	input  wire edm_mreq_t   rx_req_i,
	output edm_mrsp_t        tx_rsp_o,
	output edm_mrsp_t        rx_rsp_o,
	output edm_mreq_t        mem_o,
	input  wire logic        mem_ack_i,
	input  wire logic        mem_err_i,
	input  wire logic [31:0] mem_rdata_i
);

	typedef struct packed {
		logic      busy;
		logic      sel_rx;
		logic      done;
		edm_mreq_t mem;
		edm_mrsp_t tx_rsp;
		edm_mrsp_t rx_rsp;
	} edm_arb_st_t;

	edm_arb_st_t st;
	edm_arb_st_t next_st;

	// Receive wins ties: its FIFO overflows first when starved
	always_comb
	begin
		next_st = st;
		next_st.tx_rsp.ack = 1'b0;
		next_st.rx_rsp.ack = 1'b0;
		next_st.done = 1'b0;
		if (st.busy && mem_ack_i)
		begin
			next_st.busy = 1'b0;
			next_st.done = 1'b1;
			next_st.mem.req = 1'b0;
			if (st.sel_rx)
				next_st.rx_rsp = '{ack: 1'b1, err: mem_err_i, rdata: mem_rdata_i};
			else
				next_st.tx_rsp = '{ack: 1'b1, err: mem_err_i, rdata: mem_rdata_i};
		end
		else if (!st.busy && !st.done && (rx_req_i.req || tx_req_i.req))
		begin
			// Done cycle above skips the stale request of the answered side
			next_st.busy = 1'b1;
			next_st.sel_rx = rx_req_i.req;
			next_st.mem = rx_req_i.req ? rx_req_i : tx_req_i;
		end
	end

	// State register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			st <= '0;
		else
			st <= next_st;
	end

	assign tx_rsp_o = st.tx_rsp;
	assign rx_rsp_o = st.rx_rsp;
	assign mem_o    = st.mem;

endmodule : edm_mem_arb
`default_nettype wire

// ==== logic/edm_dma.sv ====
// Overview of operation
// - On entering running, each engine fetches from its descriptor base register.
// - After transmit, engine writes status to word 0 and clears ownership; the code writes word 0 back as fetched with only ownership cleared.
// - Transmit suspends on host-owned descriptor or error, raising status flags.
// - Transmit done flag set when completed frame requested it in word 0 bit 30.
// - Suspended transmit never self-polls; driver returns ownership then polls.
// - Suspended transmit keeps list position after last closed descriptor.
// - Receive marks first segment in bit 9 and last segment in bit 8.
// - Receive closes a descriptor on buffer full or frame end.
// - At frame end receive writes status, clears ownership, then sets done flag.
// - Receive fetches onward; on host-owned descriptor flags unavailable and suspends.
// - Frame while suspended re-fetches current descriptor; resume or discard frame.
// - Receive unavailable flag only on running-to-suspended transition.
// - Receive poll demand acts only while suspended.
// - Receive DMA cleared while MAC receiver on keeps the engine running.
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module edm_dma
	import edm_pkg::*;
(
	input  wire logic        CORE_CLK_I,
	input  wire logic        RST_I,
	input  wire logic [7:0]  S_AXI_AWADDR_I,
	input  wire logic        S_AXI_AWVALID_I,
	output logic             S_AXI_AWREADY_O,
	input  wire logic [31:0] S_AXI_WDATA_I,
	input  wire logic [3:0]  S_AXI_WSTRB_I,
	input  wire logic        S_AXI_WVALID_I,
	output logic             S_AXI_WREADY_O,
	output logic [1:0]       S_AXI_BRESP_O,
	output logic             S_AXI_BVALID_O,
	input  wire logic        S_AXI_BREADY_I,
	input  wire logic [7:0]  S_AXI_ARADDR_I,
	input  wire logic        S_AXI_ARVALID_I,
	output logic             S_AXI_ARREADY_O,
	output logic [31:0]      S_AXI_RDATA_O,
	output logic [1:0]       S_AXI_RRESP_O,
	output logic             S_AXI_RVALID_O,
	input  wire logic        S_AXI_RREADY_I,
	output logic             MEM_REQ_O,
	output logic             MEM_WE_O,
	output logic [31:0]      MEM_ADDR_O,
	output logic [31:0]      MEM_WDATA_O,
	input  wire logic        MEM_ACK_I,
	input  wire logic        MEM_ERR_I,
	input  wire logic [31:0] MEM_RDATA_I,
	output logic             TXF_VALID_O,
	output logic [31:0]      TXF_DATA_O,
	output logic             TXF_LAST_O,
	input  wire logic        TXF_READY_I,
	input  wire logic        RXF_VALID_I,
	input  wire logic [31:0] RXF_DATA_I,
	input  wire logic        RXF_LAST_I,
	output logic             RXF_READY_O,
	input  wire logic        MAC_RX_ENABLE_I
);

	typedef struct packed {
		logic                 awready;
		logic                 wready;
		logic                 bvalid;
		logic [1:0]           bresp;
		logic                 aw_have;
		logic                 w_have;
		logic [7:0]           awaddr;
		logic [31:0]          wdata;
		logic [3:0]           wstrb;
		logic                 arready;
		logic                 rvalid;
		logic [1:0]           rresp;
		logic [31:0]          rdata;
		logic [31:0]          ctrl;
		logic [31:0]          tx_base;
		logic [31:0]          rx_base;
		logic                 tx_poll;
		logic                 rx_poll;
		logic [NFLAG-1:0]     fset;
		logic [NFLAG-1:0]     fclr;
		edm_tx_state_t        tx_st;
		logic [31:0]          tx_cur;
		logic [31:0]          tx_w0;
		logic [31:0]          tx_w1;
		logic [31:0]          tx_buf;
		logic [31:0]          tx_nxt;
		logic [1:0]           tx_idx;
		logic [WCNT_W-1:0]    tx_left;
		edm_mreq_t            tx_mreq;
		logic                 txf_valid;
		logic                 txf_last;
		logic [31:0]          txf_data;
		edm_rx_state_t        rx_st;
		logic [31:0]          rx_cur;
		logic [31:0]          rx_w0;
		logic [31:0]          rx_w1;
		logic [31:0]          rx_buf;
		logic [31:0]          rx_nxt;
		logic [1:0]           rx_idx;
		logic [WCNT_W-1:0]    rx_left;
		logic [LEN_W-1:0]     rx_len;
		logic                 rx_first;
		logic                 rx_mid;
		logic                 rx_ls;
		logic                 rx_retry;
		logic                 rx_frame_wait;
		edm_mreq_t            rx_mreq;
		logic                 rxf_ready;
	} edm_st_t;

	edm_st_t   st;
	edm_st_t   next_st;
	edm_mrsp_t tx_rsp;
	edm_mrsp_t rx_rsp;
	edm_mreq_t mem;
	logic [NFLAG-1:0] flags;

	// Byte-lane merge for strobed register writes
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
				r[b*8 +: 8] = nw[b*8 +: 8];
		end
		return r;
	endfunction : wmerge

	// Words a buffer of the given byte size covers, rounded up
	function automatic logic [WCNT_W-1:0] words_of(input logic [31:0] w1);
		logic [11:0] n;
		n = (12'(w1[SIZE_W-1:0]) + BYTE_ROUND) >> WORD_SHIFT;
		return n[WCNT_W-1:0];
	endfunction : words_of

	function automatic logic [2:0] tx_code(input edm_tx_state_t s);
		return (s == TX_STOP) ? PS_STOP : (s == TX_SUSP) ? PS_SUSP : PS_RUN;
	endfunction : tx_code

	function automatic logic [2:0] rx_code(input edm_rx_state_t s);
		return (s == RX_STOP) ? PS_STOP : ((s == RX_SUSP) || (s == RX_DROP)) ? PS_SUSP : PS_RUN;
	endfunction : rx_code

	always_comb
	begin
		next_st = st;
		next_st.tx_poll = 1'b0;
		next_st.rx_poll = 1'b0;
		next_st.fset = '0;
		next_st.fclr = '0;

		// AXI4-Lite write: address and data in either order, answer after both
		if (S_AXI_AWVALID_I && st.awready)
		begin
			next_st.aw_have = 1'b1;
			next_st.awready = 1'b0;
			next_st.awaddr = S_AXI_AWADDR_I;
		end
		if (S_AXI_WVALID_I && st.wready)
		begin
			next_st.w_have = 1'b1;
			next_st.wready = 1'b0;
			next_st.wdata = S_AXI_WDATA_I;
			next_st.wstrb = S_AXI_WSTRB_I;
		end
		if (st.bvalid && S_AXI_BREADY_I)
		begin
			next_st.bvalid = 1'b0;
			next_st.awready = 1'b1;
			next_st.wready = 1'b1;
		end
		if (st.aw_have && st.w_have && !st.bvalid)
		begin
			next_st.aw_have = 1'b0;
			next_st.w_have = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = RESP_OKAY;
			case (st.awaddr)
				OFS_CTRL:    next_st.ctrl = wmerge(st.ctrl, st.wdata, st.wstrb);
				OFS_STATUS:  next_st.fclr = NFLAG'(wmerge('0, st.wdata, st.wstrb));
				OFS_TX_POLL: next_st.tx_poll = 1'b1;
				OFS_RX_POLL: next_st.rx_poll = 1'b1;
				OFS_RX_BASE: next_st.rx_base = wmerge(st.rx_base, st.wdata, st.wstrb);
				OFS_TX_BASE: next_st.tx_base = wmerge(st.tx_base, st.wdata, st.wstrb);
				OFS_TX_CUR, OFS_RX_CUR: next_st.bresp = RESP_OKAY; // Read-only, ignored
				default:     next_st.bresp = RESP_SLVERR;
			endcase
		end

		// AXI4-Lite read, one outstanding
		if (st.rvalid && S_AXI_RREADY_I)
		begin
			next_st.rvalid = 1'b0;
			next_st.arready = 1'b1;
		end
		if (S_AXI_ARVALID_I && st.arready)
		begin
			next_st.arready = 1'b0;
			next_st.rvalid = 1'b1;
			next_st.rresp = RESP_OKAY;
			case (S_AXI_ARADDR_I)
				OFS_CTRL:    next_st.rdata = st.ctrl;
				OFS_STATUS:  next_st.rdata = 32'(flags) | (32'(rx_code(st.rx_st)) << ST_RS_LSB)
						     | (32'(tx_code(st.tx_st)) << ST_TS_LSB);
				OFS_RX_BASE: next_st.rdata = st.rx_base;
				OFS_TX_BASE: next_st.rdata = st.tx_base;
				OFS_TX_CUR:  next_st.rdata = st.tx_cur;
				OFS_RX_CUR:  next_st.rdata = st.rx_cur;
				OFS_TX_POLL, OFS_RX_POLL: next_st.rdata = '0;
				default:
				begin
					next_st.rdata = '0;
					next_st.rresp = RESP_SLVERR;
				end
			endcase
		end

		// Transmit engine; request dropped on the answering cycle
		if (tx_rsp.ack)
			next_st.tx_mreq.req = 1'b0;
		if (st.txf_valid && TXF_READY_I)
			next_st.txf_valid = 1'b0;
		case (st.tx_st)
			TX_STOP:
			begin
				if (st.ctrl[CTRL_TX_START])
				begin
					next_st.tx_cur = st.tx_base;
					next_st.tx_idx = '0;
					next_st.tx_st = TX_FETCH;
				end
			end
			TX_FETCH:
			begin
				if (!st.tx_mreq.req && !tx_rsp.ack)
					next_st.tx_mreq = '{req: 1'b1, we: 1'b0, wdata: '0,
						addr: st.tx_cur + (32'(st.tx_idx) << WORD_SHIFT)};
				if (tx_rsp.ack)
				begin
					case (st.tx_idx)
						2'h0:    next_st.tx_w0 = tx_rsp.rdata;
						2'h1:    next_st.tx_w1 = tx_rsp.rdata;
						2'h2:    next_st.tx_buf = tx_rsp.rdata;
						default: next_st.tx_nxt = tx_rsp.rdata;
					endcase
					next_st.tx_idx = st.tx_idx + 2'h1;
					if (tx_rsp.err)
					begin
						next_st.fset[ST_AIS] = 1'b1;
						next_st.fset[ST_TI] = 1'b1;
						next_st.tx_st = TX_SUSP;
					end
					else if (st.tx_idx == DESC_LAST_IDX)
						next_st.tx_st = TX_CHECK;
				end
			end
			TX_CHECK:
			begin
				if (!st.tx_w0[DESC_OWN])
				begin
					// Host-owned: suspend, list position kept at tx_cur
					next_st.fset[ST_TU] = 1'b1;
					next_st.fset[ST_NIS] = 1'b1;
					next_st.tx_st = TX_SUSP;
				end
				else
				begin
					next_st.tx_left = words_of(st.tx_w1);
					next_st.tx_st = TX_DATA;
				end
			end
			TX_DATA:
			begin
				// One word in flight; the FIFO's ready stalls the walk
				if (tx_rsp.ack)
				begin
					if (tx_rsp.err)
					begin
						next_st.fset[ST_AIS] = 1'b1;
						next_st.fset[ST_TI] = 1'b1;
						next_st.tx_st = TX_SUSP;
					end
					else
					begin
						next_st.txf_valid = 1'b1;
						next_st.txf_data = tx_rsp.rdata;
						next_st.txf_last = (st.tx_left == WCNT_W'(1)) && st.tx_w1[TX_W1_LS];
						next_st.tx_buf = st.tx_buf + WORD_BYTES;
						next_st.tx_left = st.tx_left - WCNT_W'(1);
					end
				end
				else if (!st.tx_mreq.req && !st.txf_valid)
				begin
					if (st.tx_left != '0)
						next_st.tx_mreq = '{req: 1'b1, we: 1'b0, wdata: '0, addr: st.tx_buf};
					else
					begin
						next_st.tx_mreq = '{req: 1'b1, we: 1'b1, addr: st.tx_cur,
							wdata: st.tx_w0 & ~(32'h1 << DESC_OWN)};
						next_st.tx_st = TX_CLOSE;
					end
				end
			end
			TX_CLOSE:
			begin
				if (tx_rsp.ack)
				begin
					if (st.tx_w1[TX_W1_LS] && st.tx_w0[TX_W0_IOC])
						next_st.fset[ST_TI] = 1'b1;
					next_st.tx_cur = st.tx_nxt;
					next_st.tx_idx = '0;
					next_st.tx_st = st.ctrl[CTRL_TX_START] ? TX_FETCH : TX_STOP;
				end
			end
			TX_SUSP:
			begin
				// No self-polling; only a poll demand re-reads tx_cur
				if (!st.ctrl[CTRL_TX_START])
					next_st.tx_st = TX_STOP;
				else if (st.tx_poll)
				begin
					next_st.tx_idx = '0;
					next_st.tx_st = TX_FETCH;
				end
			end
			default: next_st.tx_st = TX_STOP;
		endcase

		// Receive engine
		if (rx_rsp.ack)
			next_st.rx_mreq.req = 1'b0;
		next_st.rxf_ready = 1'b0;
		case (st.rx_st)
			RX_STOP:
			begin
				if (st.ctrl[CTRL_RX_START])
				begin
					next_st.rx_cur = st.rx_base;
					next_st.rx_idx = '0;
					next_st.rx_first = 1'b1;
					next_st.rx_mid = 1'b0;
					next_st.rx_retry = 1'b0;
					next_st.rx_st = RX_FETCH;
				end
			end
			RX_FETCH:
			begin
				if (!st.rx_mreq.req && !rx_rsp.ack)
					next_st.rx_mreq = '{req: 1'b1, we: 1'b0, wdata: '0,
						addr: st.rx_cur + (32'(st.rx_idx) << WORD_SHIFT)};
				if (rx_rsp.ack)
				begin
					case (st.rx_idx)
						2'h0:    next_st.rx_w0 = rx_rsp.rdata;
						2'h1:    next_st.rx_w1 = rx_rsp.rdata;
						2'h2:    next_st.rx_buf = rx_rsp.rdata;
						default: next_st.rx_nxt = rx_rsp.rdata;
					endcase
					next_st.rx_idx = st.rx_idx + 2'h1;
					if (st.rx_idx == DESC_LAST_IDX)
						next_st.rx_st = RX_CHECK;
				end
			end
			RX_CHECK:
			begin
				next_st.rx_retry = 1'b0;
				if (st.rx_w0[DESC_OWN])
				begin
					next_st.rx_left = words_of(st.rx_w1);
					next_st.rx_len = st.rx_mid ? st.rx_len : '0;
					next_st.rx_st = (st.rx_mid || st.rx_frame_wait) ? RX_DATA : RX_WAIT;
				end
				else
				begin
					// Flag only when leaving running, not on each re-fetch
					if (!st.rx_retry)
						next_st.fset[ST_RU] = 1'b1;
					next_st.rx_st = (st.rx_mid || st.rx_frame_wait) ? RX_DROP : RX_SUSP;
				end
				next_st.rx_frame_wait = 1'b0;
			end
			RX_WAIT:
			begin
				// Clearing rx start alone does not stop a live receiver
				if (!st.ctrl[CTRL_RX_START] && !MAC_RX_ENABLE_I)
				begin
					next_st.fset[ST_RPS] = 1'b1;
					next_st.rx_st = RX_STOP;
				end
				else if (RXF_VALID_I)
					next_st.rx_st = RX_DATA;
			end
			RX_DATA:
			begin
				if (RXF_VALID_I && st.rxf_ready)
				begin
					next_st.rx_mreq = '{req: 1'b1, we: 1'b1, addr: st.rx_buf,
						wdata: RXF_DATA_I};
					next_st.rx_ls = RXF_LAST_I;
				end
				else if (rx_rsp.ack)
				begin
					next_st.rx_buf = st.rx_buf + WORD_BYTES;
					next_st.rx_left = st.rx_left - WCNT_W'(1);
					next_st.rx_len = st.rx_len + LEN_W'(1);
					if (st.rx_ls || (st.rx_left == WCNT_W'(1)))
						next_st.rx_st = RX_CLOSE;
				end
				else if (!st.rx_mreq.req && (st.rx_left == '0))
					next_st.rx_st = RX_CLOSE;
				else if (!st.rx_mreq.req && !st.rxf_ready)
					next_st.rxf_ready = 1'b1;
				if (next_st.rx_st == RX_CLOSE)
				begin
					next_st.rx_w0 = '0;
					next_st.rx_w0[RX_W0_FS] = st.rx_first;
					next_st.rx_w0[RX_W0_LS] = next_st.rx_ls;
					if (next_st.rx_ls)
						next_st.rx_w0[RX_LEN_LSB +: LEN_W] = next_st.rx_len << WORD_SHIFT;
				end
			end
			RX_CLOSE:
			begin
				if (!st.rx_mreq.req && !rx_rsp.ack)
					next_st.rx_mreq = '{req: 1'b1, we: 1'b1, addr: st.rx_cur,
						wdata: st.rx_w0};
				if (rx_rsp.ack)
				begin
					// Done flag only after the closing write is answered
					if (st.rx_ls)
						next_st.fset[ST_RI] = 1'b1;
					next_st.rx_first = st.rx_ls;
					next_st.rx_mid = !st.rx_ls;
					next_st.rx_ls = 1'b0;
					next_st.rx_cur = st.rx_nxt;
					next_st.rx_idx = '0;
					next_st.rx_st = RX_FETCH;
				end
			end
			RX_SUSP:
			begin
				// Poll demand counts only here
				if (RXF_VALID_I || st.rx_poll)
				begin
					next_st.rx_retry = 1'b1;
					next_st.rx_frame_wait = RXF_VALID_I;
					next_st.rx_idx = '0;
					next_st.rx_st = RX_FETCH;
				end
				else if (!st.ctrl[CTRL_RX_START] && !MAC_RX_ENABLE_I)
				begin
					next_st.fset[ST_RPS] = 1'b1;
					next_st.rx_st = RX_STOP;
				end
			end
			RX_DROP:
			begin
				// Frame with no buffer is drained and lost
				next_st.rxf_ready = !st.rxf_ready;
				if (RXF_VALID_I && st.rxf_ready && RXF_LAST_I)
				begin
					next_st.rxf_ready = 1'b0;
					next_st.rx_mid = 1'b0;
					next_st.rx_first = 1'b1;
					next_st.rx_st = RX_SUSP;
				end
			end
			default: next_st.rx_st = RX_STOP;
		endcase
	end

	// State register
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			st <= '0;
			st.awready <= 1'b1;
			st.wready <= 1'b1;
			st.arready <= 1'b1;
			st.tx_st <= TX_STOP;
			st.rx_st <= RX_STOP;
		end
		else
			st <= next_st;
	end

	edm_flags u_flags (
		.clk_i  (CORE_CLK_I),
		.rst_i  (RST_I),
		.set_i  (st.fset),
		.clr_i  (st.fclr),
		.flag_o (flags)
	);

	edm_mem_arb u_arb (
		.clk_i       (CORE_CLK_I),
		.rst_i       (RST_I),
		.tx_req_i    (st.tx_mreq),
		.rx_req_i    (st.rx_mreq),
		.tx_rsp_o    (tx_rsp),
		.rx_rsp_o    (rx_rsp),
		.mem_o       (mem),
		.mem_ack_i   (MEM_ACK_I),
		.mem_err_i   (MEM_ERR_I),
		.mem_rdata_i (MEM_RDATA_I)
	);

	// Outputs, all from flip-flops
	assign S_AXI_AWREADY_O = st.awready;
	assign S_AXI_WREADY_O  = st.wready;
	assign S_AXI_BRESP_O   = st.bresp;
	assign S_AXI_BVALID_O  = st.bvalid;
	assign S_AXI_ARREADY_O = st.arready;
	assign S_AXI_RDATA_O   = st.rdata;
	assign S_AXI_RRESP_O   = st.rresp;
	assign S_AXI_RVALID_O  = st.rvalid;
	assign MEM_REQ_O       = mem.req;
	assign MEM_WE_O        = mem.we;
	assign MEM_ADDR_O      = mem.addr;
	assign MEM_WDATA_O     = mem.wdata;
	assign TXF_VALID_O     = st.txf_valid;
	assign TXF_DATA_O      = st.txf_data;
	assign TXF_LAST_O      = st.txf_last;
	assign RXF_READY_O     = st.rxf_ready;

endmodule : edm_dma
`default_nettype wire

// ==== testbench/edm_dma_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module edm_dma_properties (
	input wire logic        CORE_CLK_I,
	input wire logic        RST_I,
	input wire logic        S_AXI_AWREADY_O,
	input wire logic        S_AXI_BVALID_O,
	input wire logic        S_AXI_BREADY_I,
	input wire logic        S_AXI_ARREADY_O,
	input wire logic        S_AXI_RVALID_O,
	input wire logic        S_AXI_RREADY_I,
	input wire logic        MEM_REQ_O,
	input wire logic [31:0] MEM_ADDR_O,
	input wire logic        MEM_ACK_I,
	input wire logic        TXF_VALID_O,
	input wire logic [31:0] TXF_DATA_O,
	input wire logic        TXF_READY_I,
	input wire logic        RXF_READY_O
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);
	// Memory port rests two cycles after each answer
	sequence s_mem_rest;
		!MEM_REQ_O [*2];
	endsequence
	AST_MEM_GAP: assert property (MEM_ACK_I |=> s_mem_rest) else $error("early mem request");
	AST_MEM_HOLD: assert property (MEM_REQ_O && !MEM_ACK_I |=> MEM_REQ_O && $stable(MEM_ADDR_O))
		else $error("mem request moved");
	AST_B_BUSY: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O) else $error("aw open");
	AST_B_DONE: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O && S_AXI_AWREADY_O)
		else $error("b not closed");
	AST_R_BUSY: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O) else $error("ar open");
	AST_R_DONE: assert property (S_AXI_RVALID_O && S_AXI_RREADY_I |=> !S_AXI_RVALID_O && S_AXI_ARREADY_O)
		else $error("r not closed");
	AST_TXF_HOLD: assert property (TXF_VALID_O && !TXF_READY_I |=> TXF_VALID_O && $stable(TXF_DATA_O))
		else $error("tx word moved");
	AST_RXF_PULSE: assert property (RXF_READY_O |=> !RXF_READY_O) else $error("rx ready long");
endmodule : edm_dma_properties
bind edm_dma edm_dma_properties i_edm_dma_properties (.*);
`default_nettype wire

// ==== testbench/edm_host_mem.sv ====
`timescale 1ns/100ps
`default_nettype none
module edm_host_mem (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        slow_i,
	input  wire logic        req_i,
	input  wire logic        we_i,
	input  wire logic [31:0] addr_i,
	input  wire logic [31:0] wdata_i,
	output logic             ack_o,
	output logic [31:0]      rdata_o
);
	logic [31:0] mem [0:255];
	logic [2:0]  cnt;
	initial rdata_o = 32'h5a5a5a5a;
	// Unwritten words read as host-owned descriptors
	initial foreach (mem[i]) mem[i] = '0;
	// Read data scrambles outside an answer so stale words never pass
	always @(posedge clk_i)
	begin
		ack_o <= 1'b0;
		rdata_o <= ~rdata_o;
		if (rst_i)
			cnt <= 3'h0;
		else if (req_i && !ack_o)
		begin
			cnt <= cnt + 3'h1;
			if (cnt >= (slow_i ? 3'h4 : 3'h1))
			begin
				cnt <= 3'h0;
				ack_o <= 1'b1;
				if (we_i)
					mem[addr_i[9:2]] <= wdata_i;
				else
					rdata_o <= mem[addr_i[9:2]];
			end
		end
	end
endmodule : edm_host_mem
`default_nettype wire

// ==== testbench/tb_edm_dma.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_edm_dma;
	import edm_pkg::*;
	logic clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, txr = 0;
	logic rxv = 0, rxl = 0, slow = 0, macrx = 0, merr = 0;
	logic [7:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rxd = 0, rdat;
	logic [1:0] resp;
	wire logic awr, wrdy, bv, arr, rv, mreq, mwe, ack, txv, txl, rxr;
	wire logic [1:0] br, rr;
	wire logic [31:0] rdo, ma, mwd, mrd, txd;
	logic [32:0] txq [$];
	int errors = 0, compares = 0;
	edm_dma i_edm_dma (.CORE_CLK_I(clk), .RST_I(rst), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
		.S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv),
		.S_AXI_WREADY_O(wrdy), .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry),
		.S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdo),
		.S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry), .MEM_REQ_O(mreq),
		.MEM_WE_O(mwe), .MEM_ADDR_O(ma), .MEM_WDATA_O(mwd), .MEM_ACK_I(ack), .MEM_ERR_I(merr),
		.MEM_RDATA_I(mrd), .TXF_VALID_O(txv), .TXF_DATA_O(txd), .TXF_LAST_O(txl),
		.TXF_READY_I(txr), .RXF_VALID_I(rxv), .RXF_DATA_I(rxd), .RXF_LAST_I(rxl),
		.RXF_READY_O(rxr), .MAC_RX_ENABLE_I(macrx));
	edm_host_mem i_edm_host_mem (.clk_i(clk), .rst_i(rst), .slow_i(slow), .req_i(mreq),
		.we_i(mwe), .addr_i(ma), .wdata_i(mwd), .ack_o(ack), .rdata_o(mrd));
	always #10 clk = ~clk;
	// Transmit FIFO stalls every other cycle
	always @(posedge clk)
	begin
		txr <= ~txr;
		if (txv && txr) txq.push_back({txl, txd});
	end
	task test_done;
		if (errors == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : test_done
	task chk(input string n, input logic [32:0] e, input logic [32:0] s);
		compares++;
		if (s !== e) begin errors++; $display("BAD %s exp %h got %h", n, e, s); end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		awa <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
		do begin @(posedge clk); if (awr) awv <= 0; if (wrdy) wv <= 0; end while (!bv);
		resp = br; bry <= 0; @(posedge clk);
	endtask : wr
	task rd(input logic [7:0] a);
		ara <= a; arv <= 1; rry <= 1;
		do begin @(posedge clk); if (arr) arv <= 0; end while (!rv);
		rdat = rdo; resp = rr; rry <= 0; @(posedge clk);
	endtask : rd
	task wst(input logic [31:0] m);
		rd(OFS_STATUS);
		for (int i = 0; i < 200 && (rdat & m) == 0; i++) rd(OFS_STATUS);
	endtask : wst
	// Descriptor of four words, host side
	task dsc(input logic [9:0] a, input logic [31:0] w0, w1, w2, w3);
		i_edm_host_mem.mem[a[9:2]] = w0; i_edm_host_mem.mem[a[9:2] + 1] = w1;
		i_edm_host_mem.mem[a[9:2] + 2] = w2; i_edm_host_mem.mem[a[9:2] + 3] = w3;
	endtask : dsc
	// Two-word frame; valid lowered only once the frame is over
	task rxf(input logic [31:0] a, input logic [31:0] b);
		rxv <= 1; rxd <= a; rxl <= 0;
		do @(posedge clk); while (!rxr);
		rxd <= b; rxl <= 1;
		do @(posedge clk); while (!rxr);
		rxv <= 0;
	endtask : rxf
	initial begin #400000; errors++; test_done; end
	initial
	begin
		repeat (6) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		rd(OFS_STATUS); chk("status", 0, rdat);
		rd(8'h40); chk("rresp", RESP_SLVERR, resp);
		wr(8'h40, 1); chk("bresp", RESP_SLVERR, resp);
		dsc(10'h100, 32'hc0000000, 32'h60000008, 32'h300, 32'h110);
		dsc(10'h110, 0, 32'h60000004, 32'h308, 32'h120);
		dsc(10'h300, 32'ha1, 32'ha2, 32'ha3, 0);
		wr(OFS_TX_BASE, 32'h100); wr(OFS_CTRL, 32'h2000);
		wst(32'h4);
		chk("txstat", 32'h00410005, rdat);
		chk("txown", 0, i_edm_host_mem.mem[64][31]);
		chk("tx0", {1'b0, 32'ha1}, txq[0]); chk("tx1", {1'b1, 32'ha2}, txq[1]);
		rd(OFS_TX_CUR); chk("txcur", 32'h110, rdat);
		wr(OFS_STATUS, 32'h1ffff);
		i_edm_host_mem.mem[68] = 32'h80000000;
		repeat (50) @(posedge clk);
		chk("nopoll", 2, txq.size());
		wr(OFS_TX_POLL, 1); wst(32'h4);
		chk("txstat2", 32'h00410004, rdat); chk("tx2", {1'b1, 32'ha3}, txq[2]);
		wr(OFS_STATUS, 32'h1ffff); merr <= 1; wr(OFS_TX_POLL, 1); wst(32'h8000);
		chk("txerr", 32'h00408001, rdat); merr <= 0;
		slow <= 1;
		dsc(10'h200, 32'h80000000, 8, 32'h380, 32'h210);
		dsc(10'h210, 0, 8, 32'h3c0, 32'h220);
		i_edm_host_mem.mem[136] = 0; i_edm_host_mem.mem[240] = 0;
		wr(OFS_RX_BASE, 32'h200); wr(OFS_CTRL, 32'h2002); macrx <= 1;
		rxf(32'h11, 32'h22); wst(32'h80);
		chk("rxstat", 32'h000800c0, rdat & 32'h000e01c0);
		chk("rxw0", 32'h00080300, i_edm_host_mem.mem[128]);
		chk("rxbuf", 32'h22, i_edm_host_mem.mem[225]);
		wr(OFS_STATUS, 32'h1ffff);
		rxf(32'h33, 32'h44); rd(OFS_STATUS);
		chk("rxdrop", 32'h00080000, rdat & 32'h000e01c0);
		chk("dropbuf", 0, i_edm_host_mem.mem[240]);
		i_edm_host_mem.mem[132] = 32'h80000000;
		wr(OFS_RX_POLL, 1); wst(32'h20000);
		chk("rxrun", 32'h60000, rdat & 32'he0000);
		wr(OFS_CTRL, 32'h2000);
		repeat (20) @(posedge clk);
		rd(OFS_STATUS); chk("rxstay", 32'h60000, rdat & 32'he0100);
		macrx <= 0; wst(32'h100);
		chk("rxstop", 32'h100, rdat & 32'he0100);
		wr(OFS_CTRL, 0); rd(OFS_STATUS); chk("txstop", 0, rdat & 32'h700000);
		test_done;
	end
endmodule : tb_edm_dma
`default_nettype wire
